// [hdl/peu_pin_cmd.sv]
// pin disable, enable and unblock command interpreter
`timescale 1ns/1ps
`include "peu_params.svh"
// ****************************************
// ****************************************
module peu_pin_cmd
	import peu_pkg::*;
#(
	parameter int N_PIN = 8,
	parameter bit BLOCK_SETS_EN = 1'b0
)
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic cmd_start,
	input wire logic [1:0] cmd_kind,
	input wire logic [7:0] cmd_p1,
	input wire logic [7:0] cmd_p2,
	input wire logic [7:0] cmd_lc,
	input wire logic data_valid,
	input wire logic [7:0] data_byte,
	input wire logic pers_we,
	input wire logic [4:0] pers_ref,
	input wire logic [63:0] pers_pin,
	input wire logic [63:0] pers_puk,
	output logic sw_valid_reg,
	output logic [7:0] sw1_reg,
	output logic [7:0] sw2_reg,
	output logic se_revalidate_reg,
	output logic qual_update_reg,
	output logic [4:0] qual_key_reg,
	output logic [7:0] qual_value_reg,
	output logic [N_PIN-1:0] pin_enabled_reg,
	output logic [N_PIN-1:0] pin_blocked_reg,
	output logic [N_PIN-1:0] puk_blocked_reg,
	output logic [N_PIN-1:0] access_granted_reg
);
	localparam int IDX_W = (N_PIN > 1) ? $clog2(N_PIN) : 1;

	peu_state_t state_reg;
	peu_cmd_t kind_reg;
	logic [7:0] p1_reg;
	logic [7:0] p2_reg;
	logic [7:0] lc_reg;
	logic lc_ok_reg;
	logic [63:0] pin_code_reg [N_PIN];
	logic [63:0] puk_code_reg [N_PIN];
	logic [1:0] pin_cnt_reg [N_PIN];
	logic [3:0] puk_cnt_reg [N_PIN];
	logic [N_PIN-1:0] repl_valid_reg;
	logic [4:0] repl_key_reg [N_PIN];
	logic [IDX_W-1:0] idx;
	logic [IDX_W-1:0] pers_idx;
	logic ref_ok;
	logic pers_ok;
	logic p1_ok;
	logic exec;
	logic last_byte;
	logic [4:0] byte_cnt;
	logic mismatch;
	logic [63:0] new_code;
	logic [63:0] ref_code;
	logic [15:0] sw_next;
	logic act_pin_good;
	logic act_pin_bad;
	logic act_puk_good;
	logic act_puk_bad;
	logic [1:0] sel_cnt;
	logic [3:0] sel_puk_cnt;
	logic sel_en;
	logic sel_blk;
	logic sel_puk_blk;

	// status word that reports a remaining retry count
	function automatic logic [15:0] retry_sw(input logic [3:0] left);
		retry_sw = {`PEU_SW_RETRY, left};
	endfunction

	// length byte that each command kind may legally carry
	function automatic logic lc_legal(input logic [1:0] kind, input logic [7:0] lc);
		if (kind == PEU_CMD_UNBLOCK)
			lc_legal = lc == `PEU_LC_UNBLOCK || lc == `PEU_LC_EMPTY;
		else
			lc_legal = lc == `PEU_LC_PIN;
	endfunction

	// ****************************************
	// decode of the captured command
	// ****************************************
	assign idx = p2_reg[IDX_W-1:0];
	assign ref_ok = p2_reg[`PEU_KEYREF_MSB:0] < N_PIN;
	assign pers_idx = pers_ref[IDX_W-1:0];
	assign pers_ok = pers_we && pers_ref < N_PIN;
	assign exec = state_reg == PEU_ST_EXEC;
	assign last_byte = data_valid && byte_cnt == lc_reg[4:0] - 5'h01;
	assign ref_code = (kind_reg == PEU_CMD_UNBLOCK) ? puk_code_reg[idx] : pin_code_reg[idx];
	assign sel_cnt = pin_cnt_reg[idx];
	assign sel_puk_cnt = puk_cnt_reg[idx];
	assign sel_en = pin_enabled_reg[idx];
	assign sel_blk = pin_blocked_reg[idx];
	assign sel_puk_blk = puk_blocked_reg[idx];

	// disable allows the replacement form; b6 b5 must stay zero, 01 is reserved
	always_comb
	begin
		if (kind_reg == PEU_CMD_DISABLE)
			p1_ok = p1_reg == `PEU_P1_PLAIN || (p1_reg[`PEU_P1_REPL_BIT] &&
				p1_reg[`PEU_P1_RFU_MSB:`PEU_P1_RFU_LSB] == 2'b00);
		else
			p1_ok = p1_reg == `PEU_P1_PLAIN;
	end

	// answer and action selection; checks run in order p1, length, reference
	always_comb
	begin
		sw_next = `PEU_SW_OK;
		act_pin_good = 1'b0;
		act_pin_bad = 1'b0;
		act_puk_good = 1'b0;
		act_puk_bad = 1'b0;
		if (!p1_ok)
			sw_next = `PEU_SW_WRONG_P1P2;
		else if (!lc_ok_reg)
			sw_next = `PEU_SW_WRONG_LEN;
		else if (!ref_ok)
			sw_next = `PEU_SW_REF_NOT_FOUND;
		else
		begin
			unique case (kind_reg)
				PEU_CMD_DISABLE, PEU_CMD_ENABLE:
				begin
					if (sel_blk || sel_en == (kind_reg == PEU_CMD_ENABLE))
						sw_next = `PEU_SW_NOT_ALLOWED;
					else if (mismatch)
					begin
						act_pin_bad = 1'b1;
						sw_next = retry_sw({2'b00, sel_cnt - 2'd1});
					end
					else
						act_pin_good = 1'b1;
				end
				PEU_CMD_UNBLOCK:
				begin
					if (lc_reg == `PEU_LC_EMPTY)
						sw_next = retry_sw(sel_puk_blk ? 4'h0 : sel_puk_cnt);
					else if (sel_puk_blk)
						sw_next = `PEU_SW_AUTH_BLOCKED;
					else if (mismatch)
					begin
						act_puk_bad = 1'b1;
						sw_next = retry_sw(sel_puk_cnt - 4'h1);
					end
					else
						act_puk_good = 1'b1;
				end
				default:
					sw_next = `PEU_SW_BAD_CMD;
			endcase
		end
	end

	// ****************************************
	// command sequencing
	// ****************************************
	// a wrong length goes straight to the answer so a runaway length byte never stalls us
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= PEU_ST_IDLE;
			kind_reg <= PEU_CMD_DISABLE;
			p1_reg <= 8'h00;
			p2_reg <= 8'h00;
			lc_reg <= 8'h00;
			lc_ok_reg <= 1'b0;
		end
		else
		begin
			unique case (state_reg)
				PEU_ST_IDLE:
					if (cmd_start)
					begin
						kind_reg <= peu_cmd_t'(cmd_kind);
						p1_reg <= cmd_p1;
						p2_reg <= cmd_p2;
						lc_reg <= cmd_lc;
						lc_ok_reg <= lc_legal(cmd_kind, cmd_lc);
						if (lc_legal(cmd_kind, cmd_lc) && cmd_lc != `PEU_LC_EMPTY)
							state_reg <= PEU_ST_COLLECT;
						else
							state_reg <= PEU_ST_EXEC;
					end
				PEU_ST_COLLECT:
					if (last_byte)
						state_reg <= PEU_ST_EXEC;
				PEU_ST_EXEC:
					state_reg <= PEU_ST_IDLE;
				default:
					state_reg <= PEU_ST_IDLE;
			endcase
		end
	end

	peu_data_collect peu_data_collect_i (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clear(cmd_start && state_reg == PEU_ST_IDLE),
		.data_valid(data_valid && state_reg == PEU_ST_COLLECT),
		.data_byte(data_byte),
		.ref_code(ref_code),
		.byte_cnt_reg(byte_cnt),
		.mismatch_reg(mismatch),
		.new_code_reg(new_code)
	);

	// ****************************************
	// answers and side effects
	// ****************************************
	// status word pulse, one cycle after the execute cycle
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sw_valid_reg <= 1'b0;
			sw1_reg <= 8'h00;
			sw2_reg <= 8'h00;
			se_revalidate_reg <= 1'b0;
		end
		else
		begin
			sw_valid_reg <= exec;
			se_revalidate_reg <= exec && act_pin_good;
			if (exec)
				{sw1_reg, sw2_reg} <= sw_next;
		end
	end

	// replacement key usage: set on a replacing disable, withdrawn on enable
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			qual_update_reg <= 1'b0;
			qual_key_reg <= 5'h00;
			qual_value_reg <= `PEU_QUAL_NOUSE;
			repl_valid_reg <= '0;
			for (int i = 0; i < N_PIN; i++)
				repl_key_reg[i] <= 5'h00;
		end
		else
		begin
			qual_update_reg <= 1'b0;
			if (pers_ok)
				repl_valid_reg[pers_idx] <= 1'b0;
			else if (exec && act_pin_good && kind_reg == PEU_CMD_DISABLE && p1_reg[7])
			begin
				repl_valid_reg[idx] <= 1'b1;
				repl_key_reg[idx] <= p1_reg[4:0];
				qual_update_reg <= 1'b1;
				qual_key_reg <= p1_reg[4:0];
				qual_value_reg <= `PEU_QUAL_USE;
			end
			else if (exec && act_pin_good && kind_reg == PEU_CMD_ENABLE && repl_valid_reg[idx])
			begin
				repl_valid_reg[idx] <= 1'b0;
				qual_update_reg <= 1'b1;
				qual_key_reg <= repl_key_reg[idx];
				qual_value_reg <= `PEU_QUAL_NOUSE;
			end
		end
	end

	// ****************************************
	// persistent pin state
	// ****************************************
	// only power-on, personalisation and a good unblock touch this; a new session keeps it
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			for (int i = 0; i < N_PIN; i++)
			begin
				pin_code_reg[i] <= 64'h0;
				puk_code_reg[i] <= 64'h0;
			end
		else if (pers_ok)
		begin
			pin_code_reg[pers_idx] <= pers_pin;
			puk_code_reg[pers_idx] <= pers_puk;
		end
		else if (exec && act_puk_good)
			pin_code_reg[idx] <= new_code;
	end

	// retry counters, kept across sessions so failures accumulate
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			for (int i = 0; i < N_PIN; i++)
			begin
				pin_cnt_reg[i] <= `PEU_PIN_TRIES;
				puk_cnt_reg[i] <= `PEU_PUK_TRIES;
			end
		else if (pers_ok)
		begin
			pin_cnt_reg[pers_idx] <= `PEU_PIN_TRIES;
			puk_cnt_reg[pers_idx] <= `PEU_PUK_TRIES;
		end
		else if (exec)
		begin
			if (act_pin_good || act_puk_good)
				pin_cnt_reg[idx] <= `PEU_PIN_TRIES;
			else if (act_pin_bad)
				pin_cnt_reg[idx] <= sel_cnt - 2'd1;
			if (act_puk_good)
				puk_cnt_reg[idx] <= `PEU_PUK_TRIES;
			else if (act_puk_bad)
				puk_cnt_reg[idx] <= sel_puk_cnt - 4'h1;
		end
	end

	// enabled and blocked flags; access is the inverted enabled flags, one cycle later
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pin_enabled_reg <= {N_PIN{`PEU_RST_ENABLED}};
			pin_blocked_reg <= '0;
			puk_blocked_reg <= '0;
			access_granted_reg <= '0;
		end
		else
		begin
			access_granted_reg <= ~pin_enabled_reg;
			if (pers_ok)
			begin
				pin_enabled_reg[pers_idx] <= `PEU_RST_ENABLED;
				pin_blocked_reg[pers_idx] <= 1'b0;
				puk_blocked_reg[pers_idx] <= 1'b0;
			end
			else if (exec && act_pin_good)
				pin_enabled_reg[idx] <= kind_reg == PEU_CMD_ENABLE;
			else if (exec && act_pin_bad && sel_cnt == 2'd1)
			begin
				pin_blocked_reg[idx] <= 1'b1;
				if (kind_reg == PEU_CMD_ENABLE && BLOCK_SETS_EN)
					pin_enabled_reg[idx] <= 1'b1;
			end
			else if (exec && act_puk_good)
			begin
				pin_blocked_reg[idx] <= 1'b0;
				pin_enabled_reg[idx] <= 1'b1;
			end
			else if (exec && act_puk_bad && sel_puk_cnt == 4'h1)
				puk_blocked_reg[idx] <= 1'b1;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	a_reserved_p1:
	assert property (exec && kind_reg == PEU_CMD_DISABLE && p1_reg == `PEU_P1_RESERVED
		|=> {sw1_reg, sw2_reg} == `PEU_SW_WRONG_P1P2 && $stable(sel_cnt) && $stable(sel_en))
		else $error("reserved p1 not rejected");
	a_keyref_range:
	assert property (exec && p1_ok && lc_ok_reg && !ref_ok
		|=> sw_valid_reg && {sw1_reg, sw2_reg} == `PEU_SW_REF_NOT_FOUND)
		else $error("bad key reference not rejected");
	a_enable_refused:
	assert property (exec && kind_reg == PEU_CMD_ENABLE && p1_ok && lc_ok_reg && ref_ok
		&& (sel_en || sel_blk) |=> {sw1_reg, sw2_reg} == `PEU_SW_NOT_ALLOWED && $stable(sel_cnt))
		else $error("enable not refused");
	a_disable_refused:
	assert property (exec && kind_reg == PEU_CMD_DISABLE && p1_ok && lc_ok_reg && ref_ok
		&& (!sel_en || sel_blk) |=> {sw1_reg, sw2_reg} == `PEU_SW_NOT_ALLOWED && $stable(sel_cnt))
		else $error("disable not refused");
	a_enable_good:
	assert property (exec && act_pin_good && kind_reg == PEU_CMD_ENABLE
		|=> sel_en && sel_cnt == `PEU_PIN_TRIES && {sw1_reg, sw2_reg} == `PEU_SW_OK)
		else $error("enable did not take effect");
	a_se_pulse:
	assert property (exec && act_pin_good |=> se_revalidate_reg ##1 !se_revalidate_reg)
		else $error("environment re-evaluation pulse wrong");
	a_pin_wrong:
	assert property (exec && act_pin_bad |=> sel_cnt == $past(sel_cnt) - 2'd1
		&& sel_blk == ($past(sel_cnt) == 2'd1))
		else $error("wrong pin not counted");
	a_blocked_access:
	assert property (($past(pin_enabled_reg) & $past(pin_blocked_reg) & access_granted_reg) == '0)
		else $error("blocked enabled pin grants access");
	a_unblock_good:
	assert property (exec && act_puk_good |=> sel_en && !sel_blk && sel_cnt == `PEU_PIN_TRIES
		&& sel_puk_cnt == `PEU_PUK_TRIES && pin_code_reg[idx] == $past(new_code))
		else $error("unblock did not take effect");
	a_puk_wrong:
	assert property (exec && act_puk_bad |=> sel_puk_cnt == $past(sel_puk_cnt) - 4'h1
		&& {sw1_reg, sw2_reg} == retry_sw(sel_puk_cnt))
		else $error("wrong unblock code not counted");
	a_puk_wrong_pin:
	assert property (exec && act_puk_bad |=> $stable(sel_en) && $stable(sel_blk) && $stable(sel_cnt))
		else $error("wrong unblock code changed pin");
	a_puk_block:
	assert property (exec && act_puk_bad && sel_puk_cnt == 4'h1
		|=> sel_puk_blk && {sw1_reg, sw2_reg} == retry_sw(4'h0))
		else $error("tenth failure did not block");
	a_puk_blocked_sw:
	assert property (exec && kind_reg == PEU_CMD_UNBLOCK && p1_ok && lc_ok_reg && ref_ok
		&& lc_reg != `PEU_LC_EMPTY && sel_puk_blk |=> {sw1_reg, sw2_reg} == `PEU_SW_AUTH_BLOCKED)
		else $error("blocked unblock code not refused");
	a_query_count:
	assert property (exec && kind_reg == PEU_CMD_UNBLOCK && p1_ok && ref_ok
		&& lc_reg == `PEU_LC_EMPTY |=> {sw1_reg, sw2_reg} == retry_sw(sel_puk_blk ? 4'h0 : sel_puk_cnt)
		&& $stable(sel_puk_cnt))
		else $error("unblock query answer wrong");
	a_qual_clear:
	assert property (exec && act_pin_good && kind_reg == PEU_CMD_ENABLE && repl_valid_reg[idx]
		|=> qual_update_reg && qual_value_reg == `PEU_QUAL_NOUSE && !repl_valid_reg[idx])
		else $error("replacement qualifier not cleared");

	c_enable_ok: cover property (exec && act_pin_good && kind_reg == PEU_CMD_ENABLE);
	c_puk_blocked: cover property (exec && act_puk_bad && sel_puk_cnt == 4'h1);
	c_query: cover property (exec && kind_reg == PEU_CMD_UNBLOCK && lc_reg == `PEU_LC_EMPTY);
	c_unblock_ok: cover property (exec && act_puk_good);
endmodule // peu_pin_cmd

// [hdl/peu_params.svh]
// constants of the pin enable, disable and unblock command block
`ifndef PEU_PARAMS_SVH
`define PEU_PARAMS_SVH
`define PEU_PIN_TRIES 2'd3
`define PEU_PUK_TRIES 4'd10
`define PEU_LC_PIN 8'h08
`define PEU_LC_UNBLOCK 8'h10
`define PEU_LC_EMPTY 8'h00
`define PEU_P1_PLAIN 8'h00
`define PEU_P1_RESERVED 8'h01
`define PEU_P1_REPL_BIT 7
`define PEU_P1_RFU_MSB 6
`define PEU_P1_RFU_LSB 5
`define PEU_KEYREF_MSB 4
`define PEU_CODE_BYTES 5'd8
`define PEU_QUAL_USE 8'h08
`define PEU_QUAL_NOUSE 8'h00
`define PEU_RST_ENABLED 1'b1
`define PEU_SW_OK 16'h9000
`define PEU_SW_RETRY 12'h63c
`define PEU_SW_AUTH_BLOCKED 16'h6983
`define PEU_SW_NOT_ALLOWED 16'h6985
`define PEU_SW_WRONG_LEN 16'h6700
`define PEU_SW_WRONG_P1P2 16'h6b00
`define PEU_SW_REF_NOT_FOUND 16'h6a88
`define PEU_SW_BAD_CMD 16'h6d00
`endif

// [hdl/peu_pkg.sv]
// types of the pin enable, disable and unblock command block
package peu_pkg;
	typedef enum logic [1:0] {
		PEU_ST_IDLE = 2'b00,
		PEU_ST_COLLECT = 2'b01,
		PEU_ST_EXEC = 2'b11
	} peu_state_t;
	typedef enum logic [1:0] {
		PEU_CMD_DISABLE = 2'b00,
		PEU_CMD_ENABLE = 2'b01,
		PEU_CMD_UNBLOCK = 2'b10
	} peu_cmd_t;
endpackage

// [hdl/peu_data_collect.sv]
// data field collector: checks the presented code and captures the new one
`timescale 1ns/1ps
`include "peu_params.svh"
module peu_data_collect
	import peu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic clear,
	input wire logic data_valid,
	input wire logic [7:0] data_byte,
	input wire logic [63:0] ref_code,
	output logic [4:0] byte_cnt_reg,
	output logic mismatch_reg,
	output logic [63:0] new_code_reg
);
	logic [7:0] ref_byte;
	logic in_check;

	// byte one is the most significant byte of the stored code
	assign ref_byte = ref_code[{~byte_cnt_reg[2:0], 3'b000} +: 8];
	assign in_check = byte_cnt_reg < `PEU_CODE_BYTES;

	// ****************************************
	// byte position
	// ****************************************
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			byte_cnt_reg <= 5'h00;
		else if (clear)
			byte_cnt_reg <= 5'h00;
		else if (data_valid)
			byte_cnt_reg <= byte_cnt_reg + 5'h01;
	end

	// a mismatch anywhere sticks; comparing every byte keeps the timing flat
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			mismatch_reg <= 1'b0;
		else if (clear)
			mismatch_reg <= 1'b0;
		else if (data_valid && in_check && data_byte != ref_byte)
			mismatch_reg <= 1'b1;
	end

	// bytes nine to sixteen shift in as the replacement code
	always_ff @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			new_code_reg <= 64'h0;
		else if (data_valid && !in_check)
			new_code_reg <= {new_code_reg[55:0], data_byte};
	end
endmodule // peu_data_collect

// [tb/peu_term_model.sv]
// terminal model that sends pin command headers and data bytes
`timescale 1ns/1ps
module peu_term_model
	import peu_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sw_valid_reg,
	output logic cmd_start,
	output logic [1:0] cmd_kind,
	output logic [7:0] cmd_p1,
	output logic [7:0] cmd_p2,
	output logic [7:0] cmd_lc,
	output logic data_valid,
	output logic [7:0] data_byte
);
	// ****************************************
	// command sender
	// ****************************************
	initial
	begin
		cmd_start = 1'b0;
		cmd_kind = 2'b00;
		cmd_p1 = 8'h00;
		cmd_p2 = 8'h00;
		cmd_lc = 8'h00;
		data_valid = 1'b0;
		data_byte = 8'h00;
	end
	// header, nb bytes msb first, then a bounded wait for the answer
	task automatic send(input logic [1:0] kind, input logic [7:0] p1, input logic [7:0] p2,
		input logic [7:0] lc, input int nb, input logic [127:0] dat);
		int n;
		@(posedge clk_sys);
		cmd_start <= 1'b1;
		cmd_kind <= kind;
		cmd_p1 <= p1;
		cmd_p2 <= p2;
		cmd_lc <= lc;
		for (int i = 0; i < nb; i++)
		begin
			@(posedge clk_sys);
			cmd_start <= 1'b0;
			data_valid <= 1'b1;
			data_byte <= dat[127-8*i -: 8];
		end
		@(posedge clk_sys);
		cmd_start <= 1'b0;
		data_valid <= 1'b0;
		// released byte lane toggles so a stale byte never looks valid
		data_byte <= ~data_byte;
		n = 0;
		#1;
		while (sw_valid_reg !== 1'b1 && n < 40)
		begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask
endmodule // peu_term_model

// [tb/peu_pin_cmd_tb.sv]
// self-checking bench for the pin command interpreter
`timescale 1ns/1ps
module peu_pin_cmd_tb
	import peu_pkg::*;
();
	// ****************************************
	// signals, clock and instances
	// ****************************************
	localparam logic [63:0] PIN_A = 64'h31323334ffffffff;
	localparam logic [63:0] PIN_N = 64'h39383736ffffffff;
	localparam logic [63:0] PUK_A = 64'h1122334455667788;
	localparam logic [63:0] BAD = 64'h0000000000000000;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic cmd_start, data_valid, pers_we;
	logic [1:0] cmd_kind;
	logic [7:0] cmd_p1, cmd_p2, cmd_lc, data_byte;
	logic [4:0] pers_ref = 5'h00;
	logic [63:0] pers_pin = 64'h0, pers_puk = 64'h0;
	logic sw_valid_reg, se_revalidate_reg, qual_update_reg;
	logic [7:0] sw1_reg, sw2_reg, qual_value_reg;
	logic [4:0] qual_key_reg;
	logic [7:0] pin_enabled_reg, pin_blocked_reg, puk_blocked_reg, access_granted_reg;
	int fails = 0;
	int checks_done = 0;
	initial pers_we = 1'b0;
	// free-running system clock
	initial
	begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	peu_pin_cmd #(.N_PIN(8), .BLOCK_SETS_EN(1'b0)) peu_pin_cmd_i (.clk_sys(clk_sys),
		.reset_n(reset_n), .cmd_start(cmd_start), .cmd_kind(cmd_kind), .cmd_p1(cmd_p1),
		.cmd_p2(cmd_p2), .cmd_lc(cmd_lc), .data_valid(data_valid), .data_byte(data_byte),
		.pers_we(pers_we), .pers_ref(pers_ref), .pers_pin(pers_pin), .pers_puk(pers_puk),
		.sw_valid_reg(sw_valid_reg), .sw1_reg(sw1_reg), .sw2_reg(sw2_reg),
		.se_revalidate_reg(se_revalidate_reg), .qual_update_reg(qual_update_reg),
		.qual_key_reg(qual_key_reg), .qual_value_reg(qual_value_reg),
		.pin_enabled_reg(pin_enabled_reg), .pin_blocked_reg(pin_blocked_reg),
		.puk_blocked_reg(puk_blocked_reg), .access_granted_reg(access_granted_reg));
	peu_term_model peu_term_model_i (.clk_sys(clk_sys), .sw_valid_reg(sw_valid_reg),
		.cmd_start(cmd_start), .cmd_kind(cmd_kind), .cmd_p1(cmd_p1), .cmd_p2(cmd_p2),
		.cmd_lc(cmd_lc), .data_valid(data_valid), .data_byte(data_byte));
	// ****************************************
	// compare, command and closing tasks
	// ****************************************
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_val({15'h0000, got}, {15'h0000, exp});
	endtask
	// one command; status word judged in the cycle it is flagged
	task automatic cmd(input logic [1:0] k, input logic [7:0] p1, input logic [7:0] p2,
		input logic [7:0] lc, input int nb, input logic [127:0] d, input logic [15:0] exp);
		peu_term_model_i.send(k, p1, p2, lc, nb, d);
		chk_bit(sw_valid_reg, 1'b1);
		chk_val({sw1_reg, sw2_reg}, exp);
	endtask
	task automatic pers(input logic [4:0] idx);
		@(posedge clk_sys);
		pers_we <= 1'b1;
		pers_ref <= idx;
		pers_pin <= PIN_A;
		pers_puk <= PUK_A;
		@(posedge clk_sys);
		pers_we <= 1'b0;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	// wrong then right disable, refusal when disabled, replacement key round trip
	task automatic t_dis_en;
		cmd(PEU_CMD_DISABLE, 8'h00, 8'h03, 8'h08, 8, {BAD, BAD}, 16'h63c2);
		chk_bit(pin_enabled_reg[3], 1'b1);
		cmd(PEU_CMD_DISABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h9000);
		chk_bit(se_revalidate_reg, 1'b1);
		chk_bit(pin_enabled_reg[3], 1'b0);
		cmd(PEU_CMD_DISABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h6985);
		cmd(PEU_CMD_ENABLE, 8'h00, 8'h03, 8'h08, 8, {BAD, BAD}, 16'h63c2);
		cmd(PEU_CMD_ENABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h9000);
		chk_bit(qual_update_reg, 1'b0);
		cmd(PEU_CMD_DISABLE, 8'h85, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h9000);
		chk_val({3'h0, qual_update_reg, 7'h00, qual_key_reg}, 16'h1005);
		cmd(PEU_CMD_ENABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h9000);
		chk_val({qual_update_reg, se_revalidate_reg, qual_key_reg, 1'b0, qual_value_reg},
			16'hca00);
		@(posedge clk_sys);
		#1;
		chk_bit(access_granted_reg[3], 1'b0);
	endtask
	// three wrong enables block a disabled pin, which then refuses both commands
	task automatic t_en_block;
		cmd(PEU_CMD_DISABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h9000);
		for (int i = 0; i < 3; i++)
			cmd(PEU_CMD_ENABLE, 8'h00, 8'h03, 8'h08, 8, {BAD, BAD}, 16'h63c2 - i);
		chk_val({pin_blocked_reg[3], pin_enabled_reg[3]}, 16'h0002);
		@(posedge clk_sys);
		#1;
		chk_bit(access_granted_reg[3], 1'b1);
		cmd(PEU_CMD_ENABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h6985);
		cmd(PEU_CMD_DISABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h6985);
	endtask
	// query, wrong code keeps pin blocked, right code installs the new pin
	task automatic t_unblock;
		cmd(PEU_CMD_UNBLOCK, 8'h00, 8'he3, 8'h00, 0, {BAD, BAD}, 16'h63ca);
		cmd(PEU_CMD_UNBLOCK, 8'h00, 8'h03, 8'h10, 16, {BAD, PIN_N}, 16'h63c9);
		chk_val({pin_blocked_reg[3], pin_enabled_reg[3]}, 16'h0002);
		cmd(PEU_CMD_UNBLOCK, 8'h00, 8'h03, 8'h10, 16, {PUK_A, PIN_N}, 16'h9000);
		chk_val({pin_blocked_reg[3], pin_enabled_reg[3]}, 16'h0001);
		cmd(PEU_CMD_UNBLOCK, 8'h00, 8'h03, 8'h00, 0, {BAD, BAD}, 16'h63ca);
		cmd(PEU_CMD_DISABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h63c2);
		cmd(PEU_CMD_DISABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_N, BAD}, 16'h9000);
		cmd(PEU_CMD_ENABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_N, BAD}, 16'h9000);
		cmd(PEU_CMD_ENABLE, 8'h00, 8'h03, 8'h08, 8, {PIN_N, BAD}, 16'h6985);
	endtask
	// ten wrong unblock codes on pin 5 block its unblock code; three wrong disables then
	// leave that pin blocked yet enabled, which must never grant access
	task automatic t_puk_block;
		for (int i = 0; i < 10; i++)
			cmd(PEU_CMD_UNBLOCK, 8'h00, 8'h05, 8'h10, 16, {BAD, PIN_N}, 16'h63c9 - i);
		chk_val({puk_blocked_reg[5], pin_enabled_reg[5], puk_blocked_reg[3]}, 16'h0006);
		cmd(PEU_CMD_UNBLOCK, 8'h00, 8'h05, 8'h10, 16, {PUK_A, PIN_N}, 16'h6983);
		cmd(PEU_CMD_UNBLOCK, 8'h00, 8'h05, 8'h00, 0, {BAD, BAD}, 16'h63c0);
		for (int i = 0; i < 3; i++)
			cmd(PEU_CMD_DISABLE, 8'h00, 8'h05, 8'h08, 8, {BAD, BAD}, 16'h63c2 - i);
		chk_val({pin_blocked_reg[5], pin_enabled_reg[5]}, 16'h0003);
		@(posedge clk_sys);
		#1;
		chk_bit(access_granted_reg[5], 1'b0);
	endtask
	// header refusals answer at once and leave every flag alone
	task automatic t_refuse;
		logic [41:0] tbl [9];
		logic [23:0] keep;
		tbl = '{{PEU_CMD_DISABLE, 8'h01, 8'h03, 8'h00, 16'h6b00},
			{PEU_CMD_DISABLE, 8'hc0, 8'h03, 8'h00, 16'h6b00},
			{PEU_CMD_DISABLE, 8'ha3, 8'h03, 8'h00, 16'h6b00},
			{PEU_CMD_ENABLE, 8'h01, 8'h03, 8'h00, 16'h6b00},
			{PEU_CMD_UNBLOCK, 8'h80, 8'h03, 8'h00, 16'h6b00},
			{PEU_CMD_DISABLE, 8'h00, 8'h03, 8'h00, 16'h6700},
			{PEU_CMD_ENABLE, 8'h00, 8'h03, 8'h10, 16'h6700},
			{PEU_CMD_UNBLOCK, 8'h00, 8'h03, 8'h08, 16'h6700},
			{PEU_CMD_UNBLOCK, 8'h00, 8'h09, 8'h00, 16'h6a88}};
		keep = {pin_enabled_reg, pin_blocked_reg, puk_blocked_reg};
		foreach (tbl[i])
			cmd(tbl[i][41:40], tbl[i][39:32], tbl[i][31:24], tbl[i][23:16], 0, {BAD, BAD},
				tbl[i][15:0]);
		// an undefined command kind still takes its data, then is refused
		cmd(2'b11, 8'h00, 8'h03, 8'h08, 8, {PIN_A, BAD}, 16'h6d00);
		chk_val(keep[23:8] ^ {pin_enabled_reg, pin_blocked_reg}, 16'h0000);
		chk_val({8'h00, keep[7:0] ^ puk_blocked_reg}, 16'h0000);
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial
	begin
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		#1;
		chk_val({sw1_reg, sw2_reg}, 16'h0000);
		chk_val({pin_enabled_reg, pin_blocked_reg}, 16'hff00);
		pers(5'h03);
		pers(5'h05);
		t_dis_en();
		t_en_block();
		t_unblock();
		t_puk_block();
		t_refuse();
		wrap_up();
	end
	// about fifty commands of under twenty cycles each fit well inside this span
	initial
	begin
		#200us;
		fails++;
		wrap_up();
	end
endmodule // peu_pin_cmd_tb
